//--- inc/pdc_pkg.sv
// Constants and types shared by the divider configuration slice.
package pdc_pkg;

  localparam int unsigned PDC_AW = 8;
  localparam int unsigned PDC_DW = 8;
  localparam int unsigned PDC_LS_W = 20;
  localparam int unsigned PDC_HS_W = 3;
  localparam int unsigned PDC_HS_CNT_W = 4;

  // Register offsets.
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT_HS = 8'h19;
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT1_TOP = 8'h1f;
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT1_MID = 8'h20;
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT1_LOW = 8'h21;
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT2_TOP = 8'h22;
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT2_MID = 8'h23;
  localparam logic [PDC_AW-1:0] PDC_ADDR_OUT2_LOW = 8'h24;
  localparam logic [PDC_AW-1:0] PDC_ADDR_FB_CTRL = 8'h28;
  localparam logic [PDC_AW-1:0] PDC_ADDR_FB_MID = 8'h29;
  localparam logic [PDC_AW-1:0] PDC_ADDR_FB_LOW = 8'h2a;

  // Reset values of whole registers.
  localparam logic [PDC_DW-1:0] PDC_RST_OUT_HS = 8'h20;
  localparam logic [PDC_DW-1:0] PDC_RST_OUT1_TOP = 8'h00;
  localparam logic [PDC_DW-1:0] PDC_RST_OUT1_MID = 8'h00;
  localparam logic [PDC_DW-1:0] PDC_RST_OUT1_LOW = 8'h31;
  localparam logic [PDC_DW-1:0] PDC_RST_OUT2_TOP = 8'h00;
  localparam logic [PDC_DW-1:0] PDC_RST_OUT2_MID = 8'h00;
  localparam logic [PDC_DW-1:0] PDC_RST_OUT2_LOW = 8'h31;
  localparam logic [PDC_DW-1:0] PDC_RST_FB_CTRL = 8'hc0;
  localparam logic [PDC_DW-1:0] PDC_RST_FB_MID = 8'h00;
  localparam logic [PDC_DW-1:0] PDC_RST_FB_LOW = 8'hf9;

  // Field positions inside the byte registers and the 20-bit ratio.
  localparam int unsigned PDC_HS_LSB = 5;
  localparam int unsigned PDC_HS_MSB = 7;
  localparam int unsigned PDC_NIB_MSB = 3;
  localparam int unsigned PDC_TOP_LSB = 16;
  localparam int unsigned PDC_TOP_MSB = 19;
  localparam int unsigned PDC_MID_LSB = 8;
  localparam int unsigned PDC_MID_MSB = 15;
  localparam int unsigned PDC_LOW_MSB = 7;

  // Readable bit masks; every other bit is reserved and reads zero.
  localparam logic [PDC_DW-1:0] PDC_MASK_OUT_HS = 8'he0;
  localparam logic [PDC_DW-1:0] PDC_MASK_TOP = 8'h0f;
  localparam logic [PDC_DW-1:0] PDC_MASK_FB_CTRL = 8'hef;

  // A high-speed code of zero divides by four, so the last count is code plus three.
  localparam logic [PDC_HS_CNT_W-1:0] PDC_HS_LAST_OFS = 4'h3;

endpackage : pdc_pkg

//--- inc/pdc_div_if.sv
// Connection between the register slice and one divider stage.
interface pdc_div_if;
  import pdc_pkg::*;

  logic [PDC_LS_W-1:0] ratio;
  logic stepIn;
  logic tickOut;

  modport ctl (output ratio, output stepIn, input tickOut);
  modport divider (input ratio, input stepIn, output tickOut);

endinterface : pdc_div_if

//--- hw/pdc_hs_div.sv
// High-speed divider stage, dividing its step pulses by code plus four.
module pdc_hs_div
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  pdc_div_if.divider link
);

  logic [PDC_HS_CNT_W-1:0] count;
  logic [PDC_HS_CNT_W-1:0] next_count;
  logic [PDC_HS_CNT_W-1:0] lastCount;
  logic tick;
  logic next_tick;

  assign lastCount = PDC_HS_CNT_W'(link.ratio[PDC_HS_W-1:0]) + PDC_HS_LAST_OFS;
  assign link.tickOut = tick;

  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    if (link.stepIn)
    begin
      // A code lowered mid-count must not strand the counter above its end.
      if (count >= lastCount)
      begin
        next_count = '0;
        next_tick = 1'b1;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  chk_hs_tick_end: assert property (@(posedge clk) disable iff (srst)
    link.stepIn && count >= lastCount |=> tick && count == '0)
    else $error("high-speed divider missed its terminal count");

  chk_hs_no_early: assert property (@(posedge clk) disable iff (srst)
    tick |-> $past(count) >= $past(lastCount) && $past(link.stepIn))
    else $error("high-speed divider ticked early");

endmodule : pdc_hs_div

//--- hw/pdc_ls_div.sv
// Low-speed divider stage, dividing its step pulses by field value plus one.
module pdc_ls_div
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  pdc_div_if.divider link
);

  logic [PDC_LS_W-1:0] count;
  logic [PDC_LS_W-1:0] next_count;
  logic tick;
  logic next_tick;

  assign link.tickOut = tick;

  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    if (link.stepIn)
    begin
      if (count >= link.ratio)
      begin
        next_count = '0;
        next_tick = 1'b1;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  chk_ls_tick_end: assert property (@(posedge clk) disable iff (srst)
    link.stepIn && count >= link.ratio |=> tick && count == '0)
    else $error("low-speed divider missed its terminal count");

  chk_ls_counting: assert property (@(posedge clk) disable iff (srst)
    link.stepIn && count < link.ratio |=> !tick && count == $past(count) + 1'b1)
    else $error("low-speed divider did not advance by one");

  chk_ls_idle: assert property (@(posedge clk) disable iff (srst)
    !link.stepIn |=> !tick && $stable(count))
    else $error("low-speed divider moved without a step");

endmodule : pdc_ls_div

//--- hw/pdc_regs_top.sv
// Divider configuration registers and the divider chains they steer.
//
// Contract
// - Output one field split top, middle, low.
// - Output dividers divide by field plus one.
// - Output two field uses same layout.
// - Feedback high-speed code selects four to eleven.
// - Feedback low top nibble shares control register.
// - Output low bytes reset to 0x31.
// - Feedback control register resets to 0xc0.
// - Output high-speed divider feeds both outputs.
// - Feedback middle and low bytes follow; low resets 0xf9.
module pdc_regs_top
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [PDC_AW-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [PDC_DW-1:0] regWrData,
  input wire logic regRdEn,
  output logic [PDC_DW-1:0] regRdData,
  output logic clockOutputOne,
  output logic clockOutputTwo,
  output logic phaseDetectorTick,
  output logic ratioFaultOne,
  output logic ratioFaultTwo
);

  logic [PDC_HS_W-1:0] outHsCode;
  logic [PDC_HS_W-1:0] next_outHsCode;
  logic [PDC_LS_W-1:0] out1Ratio;
  logic [PDC_LS_W-1:0] next_out1Ratio;
  logic [PDC_LS_W-1:0] out2Ratio;
  logic [PDC_LS_W-1:0] next_out2Ratio;
  logic [PDC_HS_W-1:0] fbHsCode;
  logic [PDC_HS_W-1:0] next_fbHsCode;
  logic [PDC_LS_W-1:0] fbRatio;
  logic [PDC_LS_W-1:0] next_fbRatio;
  logic [PDC_DW-1:0] next_regRdData;
  logic [PDC_DW-1:0] readValue;
  logic next_ratioFaultOne;
  logic next_ratioFaultTwo;

  pdc_div_if outHsLink ();
  pdc_div_if out1Link ();
  pdc_div_if out2Link ();
  pdc_div_if fbHsLink ();
  pdc_div_if fbLsLink ();

  // Register writes. Only the named field bits are stored, so reserved
  // bits never hold state.
  always_comb
  begin
    next_outHsCode = outHsCode;
    next_out1Ratio = out1Ratio;
    next_out2Ratio = out2Ratio;
    next_fbHsCode = fbHsCode;
    next_fbRatio = fbRatio;
    if (regWrEn)
    begin
      case (regAddr)
        PDC_ADDR_OUT_HS:
        begin
          next_outHsCode = regWrData[PDC_HS_MSB:PDC_HS_LSB];
        end
        PDC_ADDR_OUT1_TOP:
        begin
          next_out1Ratio[PDC_TOP_MSB:PDC_TOP_LSB] = regWrData[PDC_NIB_MSB:0];
        end
        PDC_ADDR_OUT1_MID:
        begin
          next_out1Ratio[PDC_MID_MSB:PDC_MID_LSB] = regWrData;
        end
        PDC_ADDR_OUT1_LOW:
        begin
          next_out1Ratio[PDC_LOW_MSB:0] = regWrData;
        end
        PDC_ADDR_OUT2_TOP:
        begin
          next_out2Ratio[PDC_TOP_MSB:PDC_TOP_LSB] = regWrData[PDC_NIB_MSB:0];
        end
        PDC_ADDR_OUT2_MID:
        begin
          next_out2Ratio[PDC_MID_MSB:PDC_MID_LSB] = regWrData;
        end
        PDC_ADDR_OUT2_LOW:
        begin
          next_out2Ratio[PDC_LOW_MSB:0] = regWrData;
        end
        PDC_ADDR_FB_CTRL:
        begin
          next_fbHsCode = regWrData[PDC_HS_MSB:PDC_HS_LSB];
          next_fbRatio[PDC_TOP_MSB:PDC_TOP_LSB] = regWrData[PDC_NIB_MSB:0];
        end
        PDC_ADDR_FB_MID:
        begin
          next_fbRatio[PDC_MID_MSB:PDC_MID_LSB] = regWrData;
        end
        PDC_ADDR_FB_LOW:
        begin
          next_fbRatio[PDC_LOW_MSB:0] = regWrData;
        end
        default:
        begin
          next_fbRatio = fbRatio;
        end
      endcase
    end
  end

  // Read decode. Unmapped offsets read zero.
  always_comb
  begin
    readValue = '0;
    case (regAddr)
      PDC_ADDR_OUT_HS:
      begin
        readValue[PDC_HS_MSB:PDC_HS_LSB] = outHsCode;
      end
      PDC_ADDR_OUT1_TOP:
      begin
        readValue[PDC_NIB_MSB:0] = out1Ratio[PDC_TOP_MSB:PDC_TOP_LSB];
      end
      PDC_ADDR_OUT1_MID:
      begin
        readValue = out1Ratio[PDC_MID_MSB:PDC_MID_LSB];
      end
      PDC_ADDR_OUT1_LOW:
      begin
        readValue = out1Ratio[PDC_LOW_MSB:0];
      end
      PDC_ADDR_OUT2_TOP:
      begin
        readValue[PDC_NIB_MSB:0] = out2Ratio[PDC_TOP_MSB:PDC_TOP_LSB];
      end
      PDC_ADDR_OUT2_MID:
      begin
        readValue = out2Ratio[PDC_MID_MSB:PDC_MID_LSB];
      end
      PDC_ADDR_OUT2_LOW:
      begin
        readValue = out2Ratio[PDC_LOW_MSB:0];
      end
      PDC_ADDR_FB_CTRL:
      begin
        readValue[PDC_HS_MSB:PDC_HS_LSB] = fbHsCode;
        readValue[PDC_NIB_MSB:0] = fbRatio[PDC_TOP_MSB:PDC_TOP_LSB];
      end
      PDC_ADDR_FB_MID:
      begin
        readValue = fbRatio[PDC_MID_MSB:PDC_MID_LSB];
      end
      PDC_ADDR_FB_LOW:
      begin
        readValue = fbRatio[PDC_LOW_MSB:0];
      end
      default:
      begin
        readValue = '0;
      end
    endcase
  end

  // The read word is captured on the request and then held, so software
  // may sample it late without racing a later write.
  always_comb
  begin
    next_regRdData = regRdEn ? readValue : regRdData;
    next_ratioFaultOne = (out1Ratio != '0) && !out1Ratio[0];
    next_ratioFaultTwo = (out2Ratio != '0) && !out2Ratio[0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outHsCode <= PDC_RST_OUT_HS[PDC_HS_MSB:PDC_HS_LSB];
      out1Ratio <= {PDC_RST_OUT1_TOP[PDC_NIB_MSB:0], PDC_RST_OUT1_MID, PDC_RST_OUT1_LOW};
      out2Ratio <= {PDC_RST_OUT2_TOP[PDC_NIB_MSB:0], PDC_RST_OUT2_MID, PDC_RST_OUT2_LOW};
      fbHsCode <= PDC_RST_FB_CTRL[PDC_HS_MSB:PDC_HS_LSB];
      fbRatio <= {PDC_RST_FB_CTRL[PDC_NIB_MSB:0], PDC_RST_FB_MID, PDC_RST_FB_LOW};
      regRdData <= '0;
      ratioFaultOne <= 1'b0;
      ratioFaultTwo <= 1'b0;
    end
    else
    begin
      outHsCode <= next_outHsCode;
      out1Ratio <= next_out1Ratio;
      out2Ratio <= next_out2Ratio;
      fbHsCode <= next_fbHsCode;
      fbRatio <= next_fbRatio;
      regRdData <= next_regRdData;
      ratioFaultOne <= next_ratioFaultOne;
      ratioFaultTwo <= next_ratioFaultTwo;
    end
  end

  // Divider chains. The synthesis clock is this clock, so each
  // high-speed stage steps on every rising edge. A ratio written byte by byte
  // is live at once; intermediate ratios may appear for a few periods.
  // output high-speed stage
  assign outHsLink.ratio = PDC_LS_W'(outHsCode);
  assign outHsLink.stepIn = 1'b1;
  // both outputs fed by one stage
  assign out1Link.ratio = out1Ratio;
  assign out1Link.stepIn = outHsLink.tickOut;
  assign out2Link.ratio = out2Ratio;
  assign out2Link.stepIn = outHsLink.tickOut;
  assign fbHsLink.ratio = PDC_LS_W'(fbHsCode);
  assign fbHsLink.stepIn = 1'b1;
  assign fbLsLink.ratio = fbRatio;
  assign fbLsLink.stepIn = fbHsLink.tickOut;

  pdc_hs_div outHsDiv (.clk(clk), .srst(srst), .link(outHsLink.divider));
  pdc_ls_div out1Div (.clk(clk), .srst(srst), .link(out1Link.divider));
  pdc_ls_div out2Div (.clk(clk), .srst(srst), .link(out2Link.divider));
  pdc_hs_div fbHsDiv (.clk(clk), .srst(srst), .link(fbHsLink.divider));
  pdc_ls_div fbLsDiv (.clk(clk), .srst(srst), .link(fbLsLink.divider));

  assign clockOutputOne = out1Link.tickOut;
  assign clockOutputTwo = out2Link.tickOut;
  assign phaseDetectorTick = fbLsLink.tickOut;

  sequence regWrite(logic [PDC_AW-1:0] addr);
    regWrEn && regAddr == addr;
  endsequence

  sequence regRead(logic [PDC_AW-1:0] addr);
    regRdEn && regAddr == addr;
  endsequence

  chk_reset_values: assert property (@(posedge clk)
    srst |=> out1Ratio[PDC_LOW_MSB:0] == PDC_RST_OUT1_LOW
      && out2Ratio[PDC_LOW_MSB:0] == PDC_RST_OUT2_LOW
      && out1Ratio[PDC_MID_MSB:PDC_MID_LSB] == PDC_RST_OUT1_MID)
    else $error("output divider reset value wrong");

  chk_fb_reset: assert property (@(posedge clk)
    srst |=> fbHsCode == PDC_RST_FB_CTRL[PDC_HS_MSB:PDC_HS_LSB]
      && fbRatio[PDC_TOP_MSB:PDC_TOP_LSB] == '0)
    else $error("feedback control reset value wrong");

  chk_fb_low_reset: assert property (@(posedge clk)
    srst |=> fbRatio[PDC_LOW_MSB:0] == PDC_RST_FB_LOW)
    else $error("feedback low byte reset value wrong");

  chk_out1_top_write: assert property (@(posedge clk) disable iff (srst)
    regWrite(PDC_ADDR_OUT1_TOP) |=>
      out1Ratio[PDC_TOP_MSB:PDC_TOP_LSB] == $past(regWrData[PDC_NIB_MSB:0])
      && out1Ratio[PDC_MID_MSB:0] == $past(out1Ratio[PDC_MID_MSB:0]))
    else $error("output one top nibble write misplaced");

  chk_out2_mid_write: assert property (@(posedge clk) disable iff (srst)
    regWrite(PDC_ADDR_OUT2_MID) |=>
      out2Ratio[PDC_MID_MSB:PDC_MID_LSB] == $past(regWrData))
    else $error("output two middle byte write misplaced");

  chk_fb_ctrl_split: assert property (@(posedge clk) disable iff (srst)
    regWrite(PDC_ADDR_FB_CTRL) |=> fbHsCode == $past(regWrData[PDC_HS_MSB:PDC_HS_LSB])
      && fbRatio[PDC_TOP_MSB:PDC_TOP_LSB] == $past(regWrData[PDC_NIB_MSB:0]))
    else $error("feedback control fields misplaced");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    (regRead(PDC_ADDR_FB_CTRL) or regRead(PDC_ADDR_OUT1_TOP) or regRead(PDC_ADDR_OUT2_TOP)
      or regRead(PDC_ADDR_OUT_HS))
      |=> (regRdData & ~(($past(regAddr) == PDC_ADDR_FB_CTRL) ? PDC_MASK_FB_CTRL
        : ($past(regAddr) == PDC_ADDR_OUT_HS) ? PDC_MASK_OUT_HS : PDC_MASK_TOP)) == '0)
    else $error("reserved bits read nonzero");

  chk_div_by_one: assert property (@(posedge clk) disable iff (srst)
    outHsLink.tickOut && out1Ratio == '0 |=> clockOutputOne)
    else $error("zero field did not divide by one");

  chk_shared_feed: assert property (@(posedge clk) disable iff (srst)
    clockOutputOne || clockOutputTwo |-> $past(outHsLink.tickOut))
    else $error("output tick without high-speed tick");

  chk_fb_feed: assert property (@(posedge clk) disable iff (srst)
    phaseDetectorTick |-> $past(fbHsLink.tickOut) && $past(fbHsCode) == $past(fbHsCode, 2)
      || $past(fbHsLink.tickOut))
    else $error("phase detector tick without feedback high-speed tick");

endmodule : pdc_regs_top

//--- tb/pdc_regs_top_tb.sv
// Self-checking testbench for the divider configuration registers and divider chains.
module pdc_regs_top_tb
  import pdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Ceiling well above the few thousand cycles the tests need.
  localparam int TLIMIT = 20000;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [PDC_AW-1:0] regAddr = '0;
  logic regWrEn = 1'b0;
  logic [PDC_DW-1:0] regWrData = '0;
  logic regRdEn = 1'b0;
  logic [PDC_DW-1:0] regRdData;
  logic clockOutputOne;
  logic clockOutputTwo;
  logic phaseDetectorTick;
  logic ratioFaultOne;
  logic ratioFaultTwo;
  int errTotal = 0;
  int numChecks = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  pdc_regs_top uut (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .clockOutputOne(clockOutputOne),
    .clockOutputTwo(clockOutputTwo), .phaseDetectorTick(phaseDetectorTick),
    .ratioFaultOne(ratioFaultOne), .ratioFaultTwo(ratioFaultTwo)
  );

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == TLIMIT)
    begin
      errTotal = errTotal + 1;
      end_sim();
    end
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    numChecks = numChecks + 1;
    if (seen !== exp)
    begin
      errTotal = errTotal + 1;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Each access is followed by an idle cycle so a strobe never toggles twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick();
    regWrEn = 1'b0;
    tick();
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
    regAddr = a;
    regRdEn = 1'b1;
    tick();
    regRdEn = 1'b0;
    tick();
    check(20'(regRdData), 20'(exp), what);
  endtask : rd_check

  task automatic do_reset;
    srst = 1'b1;
    repeat (6) tick();
    srst = 1'b0;
  endtask : do_reset

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = clockOutputOne;
      1: pick = clockOutputTwo;
      default: pick = phaseDetectorTick;
    endcase
  endfunction : pick

  // Skips two pulses so a ratio change has settled, then counts one full period.
  task automatic period_check(input int sel, input int exp, input string what);
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        tick();
        n++;
      end while (pick(sel) !== 1'b1 && n < 5000);
    end
    n = 0;
    do
    begin
      tick();
      n++;
    end while (pick(sel) !== 1'b1 && n < 5000);
    check(20'(n), 20'(exp), what);
  endtask : period_check

  task automatic test_reset_values;
    logic [7:0] addrs [11] = '{8'h19, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28,
                               8'h29, 8'h2a, 8'h30};
    logic [7:0] exps [11] = '{8'h20, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'hc0,
                              8'h00, 8'hf9, 8'h00};
    for (int i = 0; i < 11; i++)
      rd_check(addrs[i], exps[i], "reset value"); // reset contents
    $display("Test reset values done");
  endtask : test_reset_values

  task automatic test_reserved;
    wr(8'h19, 8'hff);
    wr(8'h1f, 8'hff);
    wr(8'h22, 8'hff);
    wr(8'h28, 8'hff);
    wr(8'h30, 8'hff);
    rd_check(8'h19, 8'he0, "out hs reserved"); // reserved low bits
    rd_check(8'h1f, 8'h0f, "out1 top reserved"); // top nibble only
    rd_check(8'h22, 8'h0f, "out2 top reserved"); // top nibble only
    rd_check(8'h28, 8'hef, "fb ctrl reserved"); // bit four
    rd_check(8'h30, 8'h00, "unmapped read"); // unmapped reads zero
    wr(8'h21, 8'h07);
    do_reset();
    rd_check(8'h28, 8'hc0, "fb ctrl after reset"); // mid-run reset
    rd_check(8'h21, 8'h31, "out1 low after reset"); // mid-run reset
    $display("Test reserved bits done");
  endtask : test_reserved

  task automatic test_rw;
    logic [7:0] addrs [6] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h29, 8'h2a};
    logic [7:0] vals [6] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h96, 8'h69};
    for (int i = 0; i < 6; i++)
      wr(addrs[i], vals[i]);
    for (int i = 0; i < 6; i++)
      rd_check(addrs[i], vals[i], "byte readback"); // full bytes
    $display("Test read write done");
  endtask : test_rw

  task automatic test_outputs;
    do_reset();
    wr(8'h21, 8'h01);
    wr(8'h24, 8'h03);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h19, 8'(c << 5));
      period_check(0, (c + 4) * 2, "out1 period"); // field plus one
      period_check(1, (c + 4) * 4, "out2 period"); // same encoding
    end
    wr(8'h19, 8'h00);
    wr(8'h20, 8'h01);
    period_check(0, 4 * 258, "out1 mid byte"); // middle byte placement
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    period_check(0, 4, "out1 divide by one"); // zero field
    $display("Test output dividers done");
  endtask : test_outputs

  task automatic test_feedback;
    wr(8'h29, 8'h00);
    wr(8'h2a, 8'h02);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h28, 8'(c << 5));
      period_check(2, (c + 4) * 3, "feedback period"); // code plus four
    end
    $display("Test feedback divider done");
  endtask : test_feedback

  task automatic test_fault;
    wr(8'h21, 8'h02);
    wr(8'h24, 8'h03);
    check(20'(ratioFaultOne), 20'h1, "out1 even fault"); // even field flagged
    check(20'(ratioFaultTwo), 20'h0, "out2 odd no fault"); // odd accepted
    period_check(0, 12, "out1 even period"); // still field plus one
    wr(8'h21, 8'h00);
    wr(8'h24, 8'h04);
    check(20'(ratioFaultOne), 20'h0, "out1 zero no fault"); // zero accepted
    check(20'(ratioFaultTwo), 20'h1, "out2 even fault"); // even field flagged
    $display("Test ratio fault done");
  endtask : test_fault

  initial
  begin
    do_reset();
    test_reset_values();
    test_reserved();
    test_rw();
    test_outputs();
    test_feedback();
    test_fault();
    end_sim();
  end

endmodule : pdc_regs_top_tb
